/* File: hw/itc_seq.v */
/*
 * command sequencer of an integrating converter: integration period select,
 * calibration cycling, offset null. assumes the command bus decode, the
 * converter's count and the nonvolatile store sit outside on the same clock;
 * only the line pin is asynchronous.
 */
`timescale 1ns/100ps
`include "itc_consts.vh"

module itc_seq #(
	parameter RES_W = 22 // converter result width
) (
	input wire clk_i, // module clock, 20 MHz
	input wire rst_b_i, // sync reset, active low
	input wire cmd_wr_i, // command byte write strobe
	input wire [7:0] cmd_i, // command byte
	input wire [7:0] par1_i, // parameter byte 1, low
	input wire [7:0] par2_i, // parameter byte 2, high
	input wire line_i, // line sample pin, asynchronous
	input wire [RES_W-1:0] adc_count_i, // converter count at end of window
	input wire [RES_W-1:0] nv_offset_i, // stored offset from nonvolatile store
	input wire [2:0] nv_tint_i, // stored integration code
	input wire [2:0] nv_tcal_i, // stored calibration code
	output reg busy_o, // command in progress, active high
	output reg cmd_err_o, // last command rejected
	output reg integrate_o, // integration window open
	output reg [1:0] ref_sel_o, // converter input select
	output reg [RES_W-1:0] result_o, // conversion result
	output reg result_valid_o, // result strobe, one cycle
	output reg cal_done_o, // calibration cycle done, one cycle
	output reg nv_save_o, // save strobe, one cycle
	output reg [RES_W-1:0] nv_offset_o, // offset to save
	output reg [2:0] nv_tint_o, // integration code to save
	output reg [2:0] nv_tcal_o, // calibration code to save
	output reg null_en_o, // offset subtraction on
	output reg cal_en_o, // background calibration on
	output reg [15:0] user_per_o // user period register, 100 us units
);

localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_INT = 3'h1;
localparam [2:0] S_MATH = 3'h2;
localparam [2:0] S_LINE = 3'h3;
localparam [2:0] S_FIN = 3'h4;

localparam [1:0] J_CONV = 2'h0;
localparam [1:0] J_CAL = 2'h1;
localparam [1:0] J_OFFS = 2'h2;

// tick counts are integer macros, cut to the timer width on purpose
localparam [31:0] CAL_MATH_W = `ITC_CAL_MATH_TK;
localparam [31:0] NULL_EXT_W = `ITC_NULL_EXT_TK;
localparam [31:0] OFFS_MATH_W = `ITC_OFFS_MATH_TK;
localparam [15:0] CAL_MATH = CAL_MATH_W[15:0];
localparam [15:0] NULL_EXT = NULL_EXT_W[15:0];
localparam [15:0] OFFS_MATH = OFFS_MATH_W[15:0];

reg [2:0] st_r;
reg [1:0] job_r;
reg span_r;
wire [2:0] conv_code;
reg [RES_W-1:0] raw_r;
reg boot_r;
reg tmr_load_r;
reg [15:0] tmr_val_r;
reg lm_start_r;
wire tmr_tick;
wire tmr_done;
wire lm_done;
wire [15:0] lm_period;
wire accept;
wire [15:0] par_word;

////////////////////////////////////////////////////////////////////////////////
// period code to ticks; code 7 is whatever the user register holds
function [15:0] per_ticks;
	input [2:0] code;
	input [15:0] user;
	begin
		case (code)
		3'h0: per_ticks = `ITC_PER_C0;
		3'h1: per_ticks = `ITC_PER_C1;
		3'h2: per_ticks = `ITC_PER_C2;
		3'h3: per_ticks = `ITC_PER_C3;
		3'h4: per_ticks = `ITC_PER_C4;
		3'h5: per_ticks = `ITC_PER_C5;
		3'h6: per_ticks = `ITC_PER_C6;
		default: per_ticks = user;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// sub-blocks

itc_tmr u_tmr (
	.clk_i(clk_i),
	.rst_b_i(rst_b_i),
	.load_i(tmr_load_r),
	.count_i(tmr_val_r),
	.tick_o(tmr_tick),
	.done_o(tmr_done)
);

itc_line_meas u_line (
	.clk_i(clk_i),
	.rst_b_i(rst_b_i),
	.line_i(line_i),
	.start_i(lm_start_r),
	.tick_i(tmr_tick),
	.done_o(lm_done),
	.period_o(lm_period)
);

////////////////////////////////////////////////////////////////////////////////
// command acceptance; background calibration never holds busy, so it yields
assign accept = cmd_wr_i && !busy_o;
assign par_word = {par2_i, par1_i};
assign conv_code = (cmd_i == `ITC_CMD_CONV) ? nv_tint_o : cmd_i[2:0];

// main sequencer
always @(posedge clk_i) begin
	if (!rst_b_i) begin
		st_r <= S_IDLE;
		job_r <= J_CONV;
		span_r <= 1'b0;
		raw_r <= {RES_W{1'b0}};
		boot_r <= 1'b1;
		tmr_load_r <= 1'b0;
		tmr_val_r <= 16'h0000;
		lm_start_r <= 1'b0;
		busy_o <= 1'b0;
		cmd_err_o <= 1'b0;
		integrate_o <= 1'b0;
		ref_sel_o <= `ITC_REF_INPUT;
		result_o <= {RES_W{1'b0}};
		result_valid_o <= 1'b0;
		cal_done_o <= 1'b0;
		nv_save_o <= 1'b0;
		nv_offset_o <= {RES_W{1'b0}};
		nv_tint_o <= `ITC_RST_TINT;
		nv_tcal_o <= `ITC_RST_TCAL;
		null_en_o <= 1'b0;
		cal_en_o <= 1'b0;
		user_per_o <= `ITC_RST_USER;
	end else begin
		tmr_load_r <= 1'b0;
		lm_start_r <= 1'b0;
		result_valid_o <= 1'b0;
		cal_done_o <= 1'b0;
		nv_save_o <= 1'b0;
		if (boot_r) begin
			// power-up: last saved parameters take effect
			boot_r <= 1'b0;
			nv_offset_o <= nv_offset_i;
			nv_tint_o <= nv_tint_i;
			nv_tcal_o <= nv_tcal_i;
		end else if (accept) begin
			// any running background cycle is dropped here
			busy_o <= 1'b1;
			cmd_err_o <= 1'b0;
			integrate_o <= 1'b0;
			span_r <= 1'b0;
			st_r <= S_FIN;
			if (cmd_i[7:3] == `ITC_OP_SET_INT) begin
				nv_tint_o <= cmd_i[2:0];
			end else if (cmd_i[7:3] == `ITC_OP_SET_CAL) begin
				nv_tcal_o <= cmd_i[2:0];
			end else if (cmd_i[7:3] == `ITC_OP_CONV_PRESET || cmd_i == `ITC_CMD_CONV) begin
				// preset code used once, default period untouched
				job_r <= J_CONV;
				ref_sel_o <= `ITC_REF_INPUT;
				st_r <= S_INT;
				integrate_o <= 1'b1;
				tmr_load_r <= 1'b1;
				tmr_val_r <= per_ticks(conv_code, user_per_o);
			end else begin
				case (cmd_i)
				`ITC_CMD_USER_PER: begin
					// out of range values are refused, register kept
					if (par_word >= `ITC_USER_MIN && par_word <= `ITC_USER_MAX) begin
						user_per_o <= par_word;
					end else begin
						cmd_err_o <= 1'b1;
					end
				end
				`ITC_CMD_LINE: begin
					lm_start_r <= 1'b1;
					st_r <= S_LINE;
				end
				`ITC_CMD_CAL_EN: cal_en_o <= 1'b1;
				`ITC_CMD_CAL_DIS: cal_en_o <= 1'b0;
				`ITC_CMD_CAL_ONE: begin
					job_r <= J_CAL;
					ref_sel_o <= `ITC_REF_ZERO;
					st_r <= S_INT;
					integrate_o <= 1'b1;
					tmr_load_r <= 1'b1;
					tmr_val_r <= per_ticks(nv_tcal_o, user_per_o);
				end
				`ITC_CMD_OFFS_MEAS: begin
					job_r <= J_OFFS;
					ref_sel_o <= `ITC_REF_INPUT;
					st_r <= S_INT;
					integrate_o <= 1'b1;
					tmr_load_r <= 1'b1;
					tmr_val_r <= per_ticks(nv_tint_o, user_per_o);
				end
				`ITC_CMD_NULL_EN: null_en_o <= 1'b1;
				`ITC_CMD_NULL_DIS: null_en_o <= 1'b0;
				`ITC_CMD_SAVE: nv_save_o <= 1'b1;
				`ITC_CMD_RESTORE: begin
					nv_offset_o <= nv_offset_i;
					nv_tint_o <= nv_tint_i;
					nv_tcal_o <= nv_tcal_i;
				end
				default: cmd_err_o <= 1'b1;
				endcase
			end
		end else begin
			case (st_r)
			S_IDLE: begin
				// background cycle only while nothing else is pending
				if (cal_en_o) begin
					job_r <= J_CAL;
					span_r <= 1'b0;
					ref_sel_o <= `ITC_REF_ZERO;
					st_r <= S_INT;
					integrate_o <= 1'b1;
					tmr_load_r <= 1'b1;
					tmr_val_r <= per_ticks(nv_tcal_o, user_per_o);
				end
			end
			S_INT: begin
				if (tmr_done) begin
					integrate_o <= 1'b0;
					raw_r <= adc_count_i;
					tmr_load_r <= 1'b1;
					st_r <= S_MATH;
					if (job_r == J_CAL && !span_r) begin
						// second half of the cycle on the span reference
						span_r <= 1'b1;
						ref_sel_o <= `ITC_REF_SPAN;
						integrate_o <= 1'b1;
						st_r <= S_INT;
						tmr_val_r <= per_ticks(nv_tcal_o, user_per_o);
					end else if (job_r == J_CAL) begin
						tmr_val_r <= CAL_MATH;
					end else if (job_r == J_OFFS) begin
						tmr_val_r <= OFFS_MATH;
					end else begin
						tmr_val_r <= null_en_o ? NULL_EXT : 16'h0000;
					end
				end
			end
			S_MATH: begin
				if (tmr_done) begin
					st_r <= S_FIN;
					ref_sel_o <= `ITC_REF_INPUT;
					if (job_r == J_CAL) begin
						cal_done_o <= 1'b1;
					end else if (job_r == J_OFFS) begin
						nv_offset_o <= raw_r;
					end else begin
						result_valid_o <= 1'b1;
						result_o <= null_en_o ? raw_r - nv_offset_o : raw_r;
					end
				end
			end
			S_LINE: begin
				// no timeout: a dead line pin holds busy until reset
				if (lm_done) begin
					user_per_o <= lm_period;
					st_r <= S_FIN;
				end
			end
			S_FIN: begin
				busy_o <= 1'b0;
				st_r <= S_IDLE;
			end
			default: st_r <= S_IDLE;
			endcase
		end
	end
end

endmodule

/* File: hw/itc_consts.vh */
/*
 * constants of the integration timing, calibration and null sequencer:
 * command codes, period codes, preset periods, reset values and timing counts.
 * assumes a 20 MHz module clock; all periods count in 100 us ticks.
 */
`ifndef ITC_CONSTS_VH
`define ITC_CONSTS_VH

// clock and tick
`define ITC_CLK_MHZ 20
`define ITC_TICK_NS 100000
`define ITC_TICK_CYC ((`ITC_TICK_NS * `ITC_CLK_MHZ + 999) / 1000)

// command opcodes, upper five bits carry the period code commands
`define ITC_OP_SET_INT 5'h01
`define ITC_OP_CONV_PRESET 5'h02
`define ITC_OP_SET_CAL 5'h03
`define ITC_CMD_USER_PER 8'h01
`define ITC_CMD_LINE 8'h02
`define ITC_CMD_CAL_EN 8'h03
`define ITC_CMD_CAL_DIS 8'h04
`define ITC_CMD_CAL_ONE 8'h05
`define ITC_CMD_OFFS_MEAS 8'h06
`define ITC_CMD_NULL_EN 8'h07
`define ITC_CMD_NULL_DIS 8'h20
`define ITC_CMD_SAVE 8'h21
`define ITC_CMD_RESTORE 8'h22
`define ITC_CMD_CONV 8'h23

// preset periods in 100 us ticks, codes 0..6; code 7 picks the user register
`define ITC_PER_C0 16'h000A
`define ITC_PER_C1 16'h0064
`define ITC_PER_C2 16'h00A7
`define ITC_PER_C3 16'h00C8
`define ITC_PER_C4 16'h03E8
`define ITC_PER_C5 16'h0683
`define ITC_PER_C6 16'h0BB8
`define ITC_CODE_USER 3'h7
`define ITC_USER_MIN 16'h000A
`define ITC_USER_MAX 16'h0DAC

// reset values
`define ITC_RST_TINT 3'h2
`define ITC_RST_TCAL 3'h4
`define ITC_RST_USER 16'h00A7

// computation times in microseconds and their tick counts (rounded up)
`define ITC_CAL_MATH_US 9000
`define ITC_NULL_EXT_US 700
`define ITC_OFFS_MATH_US 3000
`define ITC_CAL_MATH_TK ((`ITC_CAL_MATH_US * 1000 + `ITC_TICK_NS - 1) / `ITC_TICK_NS)
`define ITC_NULL_EXT_TK ((`ITC_NULL_EXT_US * 1000 + `ITC_TICK_NS - 1) / `ITC_TICK_NS)
`define ITC_OFFS_MATH_TK ((`ITC_OFFS_MATH_US * 1000 + `ITC_TICK_NS - 1) / `ITC_TICK_NS)

// reference select
`define ITC_REF_INPUT 2'h0
`define ITC_REF_ZERO 2'h1
`define ITC_REF_SPAN 2'h2

`endif

/* File: hw/itc_tmr.v */
/*
 * tick timer: loads a count of 100 us ticks and runs it down.
 * assumes load_i is a one-cycle pulse from logic on the same clock.
 */
`timescale 1ns/100ps
`include "itc_consts.vh"

module itc_tmr (
	input wire clk_i, // module clock
	input wire rst_b_i, // sync reset, active low
	input wire load_i, // load pulse
	input wire [15:0] count_i, // ticks to run
	output wire tick_o, // one-cycle tick pulse
	output wire done_o // count ran out
);

// full-width copy first, then cut to the prescaler width on purpose
localparam [31:0] TICK_LAST_W = `ITC_TICK_CYC - 1;
localparam [11:0] TICK_LAST = TICK_LAST_W[11:0];

reg [11:0] pre_r;
reg [15:0] cnt_r;

////////////////////////////////////////////////////////////////////////////////
// prescaler restarts on load so the first tick is a full tick
always @(posedge clk_i) begin
	if (!rst_b_i) begin
		pre_r <= 12'h000;
		cnt_r <= 16'h0000;
	end else if (load_i) begin
		pre_r <= 12'h000;
		cnt_r <= count_i;
	end else if (pre_r == TICK_LAST) begin
		pre_r <= 12'h000;
		if (cnt_r != 16'h0000) begin
			cnt_r <= cnt_r - 16'h0001;
		end
	end else begin
		pre_r <= pre_r + 12'h001;
	end
end

assign tick_o = (pre_r == TICK_LAST);
// masked in the load cycle so a stale zero never reads as done
assign done_o = (cnt_r == 16'h0000) && !load_i;

endmodule

/* File: hw/itc_line_meas.v */
/*
 * line period measurement: rising edge to rising edge of the line pin,
 * counted in 100 us ticks. assumes a clean signal; with none it waits forever.
 */
`timescale 1ns/100ps

module itc_line_meas (
	input wire clk_i, // module clock
	input wire rst_b_i, // sync reset, active low
	input wire line_i, // line pin, asynchronous
	input wire start_i, // start pulse
	input wire tick_i, // 100 us tick
	output reg done_o, // measurement finished pulse
	output reg [15:0] period_o // measured ticks
);

localparam [1:0] LM_IDLE = 2'h0;
localparam [1:0] LM_ARM = 2'h1;
localparam [1:0] LM_CNT = 2'h2;

reg line_s1_r;
reg line_s2_r;
reg line_d_r;
reg [1:0] st_r;
reg [15:0] cnt_r;
wire rise;

////////////////////////////////////////////////////////////////////////////////
// two-stage synchroniser, edge detection on the second stage only
always @(posedge clk_i) begin
	if (!rst_b_i) begin
		line_s1_r <= 1'b0;
		line_s2_r <= 1'b0;
		line_d_r <= 1'b0;
	end else begin
		line_s1_r <= line_i;
		line_s2_r <= line_s1_r;
		line_d_r <= line_s2_r;
	end
end

assign rise = line_s2_r && !line_d_r;

// edge to edge counter, saturates instead of wrapping
always @(posedge clk_i) begin
	if (!rst_b_i) begin
		st_r <= LM_IDLE;
		cnt_r <= 16'h0000;
		done_o <= 1'b0;
		period_o <= 16'h0000;
	end else begin
		done_o <= 1'b0;
		case (st_r)
		LM_IDLE: begin
			if (start_i) begin
				st_r <= LM_ARM;
			end
		end
		LM_ARM: begin
			cnt_r <= 16'h0000;
			if (rise) begin
				st_r <= LM_CNT;
			end
		end
		LM_CNT: begin
			if (rise) begin
				period_o <= cnt_r;
				done_o <= 1'b1;
				st_r <= LM_IDLE;
			end else if (tick_i && cnt_r != 16'hFFFF) begin
				cnt_r <= cnt_r + 16'h0001;
			end
		end
		default: begin
			st_r <= LM_IDLE;
		end
		endcase
	end
end

endmodule

/* File: verif/itc_seq_assertions.sv */
/* checker of the sequencer: command taking, busy, pulses and calibration.
   assumes it is bound to itc_seq and sees only that module's ports. */
`timescale 1ns/100ps
`include "itc_consts.vh"
module itc_seq_chk (
	input wire clk_i, // module clock
	input wire rst_b_i, // sync reset, active low
	input wire cmd_wr_i, // command strobe
	input wire [7:0] cmd_i, // command byte
	input wire busy_o, // busy
	input wire integrate_o, // window open
	input wire [1:0] ref_sel_o, // input select
	input wire result_valid_o, // result strobe
	input wire nv_save_o, // save strobe
	input wire [2:0] nv_tint_o, // default integration code
	input wire [2:0] nv_tcal_o, // default calibration code
	input wire null_en_o, // subtraction on
	input wire cal_en_o // background calibration on
);
	reg rdy_r; // low on the boot edge, which ignores strobes
	wire take = rdy_r && cmd_wr_i && !busy_o;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	//////////////////////////////////////////////////
	// boot tracker
	always @(posedge clk_i) begin
		rdy_r <= rst_b_i;
	end
	// command port
	busy_take_a: assert property (take |=> busy_o)
		else $error("busy not raised");
	busy_ign_a: assert property (rdy_r && cmd_wr_i && busy_o |=> $stable(null_en_o)
		&& $stable(cal_en_o) && $stable(nv_tcal_o))
		else $error("command taken while busy");
	set_int_a: assert property (take && cmd_i[7:3] == `ITC_OP_SET_INT
		|=> nv_tint_o == $past(cmd_i[2:0]))
		else $error("integration code not stored");
	set_cal_a: assert property (take && cmd_i[7:3] == `ITC_OP_SET_CAL
		|=> nv_tcal_o == $past(cmd_i[2:0]))
		else $error("calibration code not stored");
	conv_keep_a: assert property (take && cmd_i[7:3] == `ITC_OP_CONV_PRESET
		|=> $stable(nv_tint_o) [*3])
		else $error("default period changed by conversion");
	null_on_a: assert property (take && cmd_i == `ITC_CMD_NULL_EN |=> null_en_o)
		else $error("null not enabled");
	null_off_a: assert property (take && cmd_i == `ITC_CMD_NULL_DIS |=> !null_en_o)
		else $error("null not disabled");
	// calibration and result strobe
	bg_ref_a: assert property (integrate_o && !busy_o |-> ref_sel_o != `ITC_REF_INPUT)
		else $error("background window on input");
	cal_abort_a: assert property (take && integrate_o && !busy_o
		|=> busy_o && !(integrate_o && ref_sel_o != `ITC_REF_INPUT))
		else $error("calibration not aborted");
	cal_idle_a: assert property (!cal_en_o && !busy_o |-> !integrate_o)
		else $error("window open while idle");
	valid_end_a: assert property (result_valid_o |=> !result_valid_o && !busy_o)
		else $error("result strobe or busy late");
	cover property (take && cmd_i[7:3] == `ITC_OP_CONV_PRESET);
	cover property (integrate_o && !busy_o);
	cover property (nv_save_o);
	cover property (integrate_o && busy_o && ref_sel_o == `ITC_REF_SPAN);
endmodule
bind itc_seq itc_seq_chk chk_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_wr_i(cmd_wr_i),
	.cmd_i(cmd_i), .busy_o(busy_o), .integrate_o(integrate_o), .ref_sel_o(ref_sel_o),
	.result_valid_o(result_valid_o), .nv_save_o(nv_save_o), .nv_tint_o(nv_tint_o),
	.nv_tcal_o(nv_tcal_o), .null_en_o(null_en_o), .cal_en_o(cal_en_o));

/* File: verif/itc_front.sv */
/* far side model: line source, converter count and parameter store.
   assumes one clock shared with the sequencer. */
`timescale 1ns/100ps
module itc_front #(
	parameter LINE_CYC = 24000, // line period in clocks
	parameter [21:0] COUNT = 22'h0ABCDE, // count at end of each window
	parameter [21:0] OFFS = 22'h000123 // stored offset at power-up
) (
	input wire clk_i, // module clock
	input wire line_on_i, // line source running
	input wire save_i, // save strobe
	input wire [21:0] offs_i, // offset to save
	input wire [2:0] tint_i, // integration code to save
	input wire [2:0] tcal_i, // calibration code to save
	output reg line_o, // line pin
	output wire [21:0] count_o, // converter count
	output reg [21:0] offs_o, // stored offset
	output reg [2:0] tint_o, // stored integration code
	output reg [2:0] tcal_o // stored calibration code
);
	reg [15:0] half_r; // half period count
	assign count_o = COUNT;
	//////////////////////////////////////////////////
	// stored set differs from reset values so a boot load shows
	initial begin
		line_o = 1'b0;
		half_r = 16'h0000;
		offs_o = OFFS;
		tint_o = 3'h3;
		tcal_o = 3'h5;
	end
	// clean square wave only while sampling is wanted, low otherwise
	always @(posedge clk_i) begin
		if (!line_on_i) begin
			half_r <= 16'h0000;
			line_o <= 1'b0;
		end else if (half_r == LINE_CYC / 2 - 1) begin
			half_r <= 16'h0000;
			line_o <= !line_o;
		end else begin
			half_r <= half_r + 16'h0001;
		end
	end
	// store keeps the last saved set for restore and power-up
	always @(posedge clk_i) begin
		if (save_i) begin
			offs_o <= offs_i;
			tint_o <= tint_i;
			tcal_o <= tcal_i;
		end
	end
endmodule

/* File: verif/test_itc_seq.sv */
/* testbench of the sequencer: one task per scenario against the far side model.
   assumes the tick count in the shared constants keeps its 20 MHz value. */
`timescale 1ns/100ps
`include "itc_consts.vh"
module test_itc_seq;
	localparam [21:0] COUNT = 22'h0ABCDE;
	localparam [21:0] OFFS = 22'h000123;
	reg clk_i = 1'b0;
	reg rst_b_i = 1'b0;
	reg cmd_wr_i = 1'b0;
	reg [7:0] cmd_i = 8'h00;
	reg [7:0] par1_i = 8'h00;
	reg [7:0] par2_i = 8'h00;
	reg line_on = 1'b0;
	wire line_i, busy_o, cmd_err_o, integrate_o, result_valid_o, nv_save_o, null_en_o, cal_en_o;
	wire cal_done_o;
	wire [1:0] ref_sel_o;
	wire [2:0] nv_tint_i, nv_tcal_i, nv_tint_o, nv_tcal_o;
	wire [15:0] user_per_o;
	wire [21:0] adc_count_i, nv_offset_i, result_o, nv_offset_o;
	integer mismatches = 0;
	integer num_checks = 0;
	integer i, n, w;
	itc_seq #(.RES_W(22)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_wr_i(cmd_wr_i),
		.cmd_i(cmd_i), .par1_i(par1_i), .par2_i(par2_i), .line_i(line_i),
		.adc_count_i(adc_count_i), .nv_offset_i(nv_offset_i), .nv_tint_i(nv_tint_i),
		.nv_tcal_i(nv_tcal_i), .busy_o(busy_o), .cmd_err_o(cmd_err_o),
		.integrate_o(integrate_o), .ref_sel_o(ref_sel_o), .result_o(result_o),
		.result_valid_o(result_valid_o), .cal_done_o(cal_done_o), .nv_save_o(nv_save_o),
		.nv_offset_o(nv_offset_o), .nv_tint_o(nv_tint_o), .nv_tcal_o(nv_tcal_o),
		.null_en_o(null_en_o), .cal_en_o(cal_en_o), .user_per_o(user_per_o));
	itc_front #(.LINE_CYC(8000), .COUNT(COUNT), .OFFS(OFFS)) front (.clk_i(clk_i),
		.line_on_i(line_on), .save_i(nv_save_o), .offs_i(nv_offset_o), .tint_i(nv_tint_o),
		.tcal_i(nv_tcal_o),
		.line_o(line_i), .count_o(adc_count_i), .offs_o(nv_offset_i), .tint_o(nv_tint_i),
		.tcal_o(nv_tcal_i));
	//////////////////////////////////////////////////
	// shared tasks
	task step;
		begin
			@(posedge clk_i);
			#5;
		end
	endtask
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("ERROR %s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	// parameters settle a cycle ahead of the strobe
	task cmd(input [7:0] c, input [15:0] p);
		begin
			step;
			par1_i = p[7:0];
			par2_i = p[15:8];
			step;
			cmd_i = c;
			cmd_wr_i = 1'b1;
			step;
			cmd_wr_i = 1'b0;
		end
	endtask
	task idle(input integer lim);
		begin
			n = 0;
			while (busy_o !== 1'b0 && n < lim) begin
				step;
				n = n + 1;
			end
			chk("busy", busy_o, 0);
		end
	endtask
	task run(input [7:0] c, input [15:0] p);
		begin
			cmd(c, p);
			idle(100);
		end
	endtask
	task results;
		begin
			if (mismatches == 0 && num_checks > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	//////////////////////////////////////////////////
	// scenarios
	task t_boot;
		begin
			step;
			step;
			chk("boot", {nv_tint_o, nv_tcal_o, user_per_o}, {3'h3, 3'h5, `ITC_RST_USER});
			chk("boot_offs", nv_offset_o, OFFS);
		end
	endtask
	task t_codes;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				run({`ITC_OP_SET_INT, i[2:0]}, 16'h0000);
				chk("tint", nv_tint_o, i);
				run({`ITC_OP_SET_CAL, i[2:0]}, 16'h0000);
				chk("tcal", nv_tcal_o, i);
			end
		end
	endtask
	task t_line;
		begin
			line_on = 1'b1;
			cmd(`ITC_CMD_LINE, 16'h0000);
			idle(15000);
			line_on = 1'b0;
			// 8000 clocks of line period are 4 ticks, one tick of slack each way
			chk("line_per", user_per_o > 16'h0002 && user_per_o < 16'h0006, 1);
		end
	endtask
	task t_user;
		begin
			run(`ITC_CMD_USER_PER, `ITC_USER_MAX);
			chk("user_max", {cmd_err_o, user_per_o}, {1'b0, `ITC_USER_MAX});
			run(`ITC_CMD_USER_PER, `ITC_USER_MAX + 16'h0001);
			chk("user_high", {cmd_err_o, user_per_o}, {1'b1, `ITC_USER_MAX});
			run(`ITC_CMD_USER_PER, `ITC_USER_MIN - 16'h0001);
			chk("user_low", {cmd_err_o, user_per_o}, {1'b1, `ITC_USER_MAX});
			run(`ITC_CMD_USER_PER, `ITC_USER_MIN);
			chk("user_min", {cmd_err_o, user_per_o}, {1'b0, `ITC_USER_MIN});
		end
	endtask
	// user period of 10 ticks, null on, a disable strobe lands while busy
	task t_conv;
		begin
			run(`ITC_CMD_NULL_EN, 16'h0000);
			chk("null_en", null_en_o, 1);
			run(8'h0B, 16'h0000);
			cmd(8'h17, 16'h0000);
			cmd(`ITC_CMD_NULL_DIS, 16'h0000);
			n = 0;
			w = 0;
			while (result_valid_o !== 1'b1 && n < 40000) begin
				step;
				n = n + 1;
				if (integrate_o === 1'b1)
					w = w + 1;
			end
			chk("window", w > 19990 && w < 20005, 1);
			chk("null_time", n > 33990 && n < 34010, 1);
			chk("result", result_o, COUNT - OFFS);
			chk("kept", {null_en_o, nv_tint_o}, {1'b1, 3'h3});
			idle(10);
			run(`ITC_CMD_NULL_DIS, 16'h0000);
			chk("null_dis", null_en_o, 0);
		end
	endtask
	task t_save;
		begin
			run(8'h09, 16'h0000);
			run(`ITC_CMD_SAVE, 16'h0000);
			run(8'h0C, 16'h0000);
			run(`ITC_CMD_RESTORE, 16'h0000);
			chk("restore", {nv_tint_o, nv_offset_o}, {3'h1, OFFS});
		end
	endtask
	task t_cal;
		begin
			run(`ITC_CMD_CAL_EN, 16'h0000);
			chk("cal_en", cal_en_o, 1);
			i = 0;
			while (integrate_o !== 1'b1 && i < 50) begin
				step;
				i = i + 1;
			end
			chk("bg_cal", {busy_o, integrate_o, ref_sel_o}, {2'b01, `ITC_REF_ZERO});
			cmd(`ITC_CMD_CAL_DIS, 16'h0000);
			chk("abort", {cal_done_o, integrate_o}, 0);
			idle(10);
			repeat (100) step;
			chk("idle", {cal_en_o, integrate_o}, 0);
		end
	endtask
	// single calibration on code 0, cut short by a reset in mid-run
	task t_one;
		begin
			run({`ITC_OP_SET_CAL, 3'h0}, 16'h0000);
			cmd(`ITC_CMD_CAL_ONE, 16'h0000);
			chk("one_zero", {busy_o, integrate_o, ref_sel_o}, {2'b11, `ITC_REF_ZERO});
			n = 0;
			while (ref_sel_o !== `ITC_REF_SPAN && n < 21000) begin
				step;
				n = n + 1;
			end
			chk("one_span", {busy_o, integrate_o, cal_done_o}, 3'b110);
			chk("zero_win", n > 19990 && n < 20010, 1);
			rst_b_i = 1'b0;
			repeat (6) step;
			rst_b_i = 1'b1;
			step;
			step;
			chk("reboot", {busy_o, integrate_o}, 0);
			chk("reboot_nv", {nv_tcal_o, user_per_o}, {3'h7, `ITC_RST_USER});
		end
	endtask
	//////////////////////////////////////////////////
	// clock, main sequence, watchdog
	initial begin
		forever #25 clk_i = ~clk_i;
	end
	initial begin
		repeat (6) @(posedge clk_i);
		#5;
		rst_b_i = 1'b1;
		t_boot;
		t_codes;
		t_line;
		t_user;
		t_conv;
		t_save;
		t_cal;
		t_one;
		results;
	end
	// whole run needs about 67000 clocks
	initial begin
		#4500000;
		mismatches = mismatches + 1;
		results;
	end
endmodule
